//--- src/pxb_crossbar.sv
`timescale 1ns/1ns
// Operation
// - SMBus enable claims data and clock pins together, never just one.
// - UART enable hands out transmit and receive pins as a pair.
// - UART transmit fixed on port 0 bit 4, receive on bit 5.
// - Unclaimed, unskipped pins stay ordinary port I/O.
// - SPI slave select gets a pin only in four-wire mode.
// - Analog pins lose pullup, output driver and input receiver.
// - Input mode bit 1 means digital, 0 means analog.
// - Reset leaves every pin a digital input.
// - Port 0 overdrive bit 1 selects high impedance; ports 1, 2 normal.
// - Output mode bit picks open-drain or push-pull, also for peripherals.
// - SMBus pins always drive open-drain.
// - Pullup-disable 0 enables weak pullup on open-drain pins only.
// - Pullup off on pins driving low and on analog pins.
// - Crossbar disabled: pins plain inputs, routing ignored.
// - Output drivers disabled while crossbar disabled.
// - Routing registers hold one enable each for UART, SPI and SMBus, one per other function, plus a 3-bit capture output count.
// - Each function except UART takes lowest free unskipped pin.
// - Functions served in fixed priority, UART first.
module pxb_crossbar
  import pxb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire pxb_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire logic spi_four_wire,
  input wire pxb_periph_t periph,
  output logic [NUM_FUNC-1:0] periph_in,
  input wire logic [NUM_PINS-1:0] port_latch,
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe_n,
  output logic [NUM_PINS-1:0] pin_pullup_en,
  output logic [PORT_W-1:0] pin_odhiz,
  output logic [NUM_PINS-1:0] pin_level
);
  logic [7:0] route_low_reg;
  logic [7:0] route_high_reg;
  logic [NUM_PINS-1:0] in_mode_reg;
  logic [NUM_PINS-1:0] out_mode_reg;
  logic [NUM_PINS-1:0] skip_reg;
  logic [PORT_W-1:0] overdrive_reg;
  logic [CNT_W-1:0] claimed_reg;
  logic [CNT_W-1:0] claimed_next;
  pxb_slot_t map_reg [NUM_FUNC];
  pxb_slot_t map_next [NUM_FUNC];
  logic [NUM_FUNC-1:0] want;
  logic [NUM_PINS-1:0] pin_sync;
  logic [NUM_PINS-1:0] own_valid;
  logic [PIN_IDX_W-1:0] own_func [NUM_PINS];
  logic [NUM_PINS-1:0] smb_pin;
  logic xbar_en;
  logic pud;

  assign xbar_en = route_high_reg[B_XBAR_EN];
  assign pud = route_high_reg[B_PUD];

  // ==========================================================================
  // Pin synchroniser
  pxb_sync2 #(
    .W(NUM_PINS)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .d(pin_in),
    .q(pin_sync)
  );

  // ==========================================================================
  // Register writes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      route_low_reg <= RST_ROUTE;
      route_high_reg <= RST_ROUTE;
    end else if (sfr_req.wr) begin
      if (sfr_req.addr == ADDR_ROUTE_LOW) begin
        route_low_reg <= sfr_req.wdata;
      end
      if (sfr_req.addr == ADDR_ROUTE_HIGH) begin
        route_high_reg <= sfr_req.wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_mode_reg <= RST_IN_MODE;
      out_mode_reg <= RST_OUT_MODE;
      skip_reg <= RST_SKIP;
      overdrive_reg <= RST_OVERDRIVE;
    end else if (sfr_req.wr) begin
      case (sfr_req.addr)
        ADDR_IN_MODE0: in_mode_reg[7:0] <= sfr_req.wdata;
        ADDR_IN_MODE1: in_mode_reg[15:8] <= sfr_req.wdata;
        ADDR_IN_MODE2: in_mode_reg[23:16] <= sfr_req.wdata;
        ADDR_OUT_MODE0: out_mode_reg[7:0] <= sfr_req.wdata;
        ADDR_OUT_MODE1: out_mode_reg[15:8] <= sfr_req.wdata;
        ADDR_OUT_MODE2: out_mode_reg[23:16] <= sfr_req.wdata;
        ADDR_SKIP0: skip_reg[7:0] <= sfr_req.wdata;
        ADDR_SKIP1: skip_reg[15:8] <= sfr_req.wdata;
        ADDR_SKIP2: skip_reg[23:16] <= sfr_req.wdata;
        ADDR_OVERDRIVE: overdrive_reg <= sfr_req.wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Register reads, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_req.rd) begin
      case (sfr_req.addr)
        ADDR_ROUTE_LOW: sfr_rdata <= route_low_reg;
        ADDR_ROUTE_HIGH: sfr_rdata <= route_high_reg;
        ADDR_CLAIMED: sfr_rdata <= {3'h0, claimed_reg};
        ADDR_IN_MODE0: sfr_rdata <= in_mode_reg[7:0];
        ADDR_IN_MODE1: sfr_rdata <= in_mode_reg[15:8];
        ADDR_IN_MODE2: sfr_rdata <= in_mode_reg[23:16];
        ADDR_OUT_MODE0: sfr_rdata <= out_mode_reg[7:0];
        ADDR_OUT_MODE1: sfr_rdata <= out_mode_reg[15:8];
        ADDR_OUT_MODE2: sfr_rdata <= out_mode_reg[23:16];
        ADDR_SKIP0: sfr_rdata <= skip_reg[7:0];
        ADDR_SKIP1: sfr_rdata <= skip_reg[15:8];
        ADDR_SKIP2: sfr_rdata <= skip_reg[23:16];
        ADDR_OVERDRIVE: sfr_rdata <= overdrive_reg;
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // Requested functions; nothing is requested while disabled
  always_comb begin
    logic [CEX_W-1:0] cex_n;
    cex_n = route_high_reg[B_CEX_LSB +: CEX_W];
    want = '0;
    want[F_TX] = route_low_reg[B_UART];
    want[F_RX] = route_low_reg[B_UART];
    want[F_SCK] = route_low_reg[B_SPI];
    want[F_MISO] = route_low_reg[B_SPI];
    want[F_MOSI] = route_low_reg[B_SPI];
    want[F_NSS] = route_low_reg[B_SPI] & spi_four_wire;
    want[F_SDA] = route_low_reg[B_SMB];
    want[F_SCL] = route_low_reg[B_SMB];
    want[F_CP0] = route_low_reg[B_CMP0];
    want[F_CP0A] = route_low_reg[B_CMP0A];
    want[F_CP1] = route_low_reg[B_CMP1];
    want[F_CP1A] = route_low_reg[B_CMP1A];
    want[F_SYSCLK] = route_low_reg[B_SYSCLK];
    // Reserved capture count routes no capture output
    for (int c = 0; c < CEX_MAX; c++) begin
      want[F_CAPTURE_OUTPUT_ZERO + c] = (int'(cex_n) > c) && (int'(cex_n) <= CEX_MAX);
    end
    want[F_ECI] = route_high_reg[B_ECI];
    want[F_T0] = route_high_reg[B_T0];
    want[F_T1] = route_high_reg[B_T1];
    if (!xbar_en) begin
      want = '0;
    end
  end

  // ==========================================================================
  // Priority decoder
  function automatic pxb_slot_t first_free(input logic [NUM_PINS-1:0] m);
    pxb_slot_t s;
    s = '0;
    for (int p = NUM_PINS - 1; p >= 0; p--) begin
      if (!m[p]) begin
        s.valid = 1'b1;
        s.pin = PIN_IDX_W'(p);
      end
    end
    return s;
  endfunction

  always_comb begin
    logic [NUM_PINS-1:0] taken;
    pxb_slot_t a;
    pxb_slot_t b;
    taken = skip_reg;
    a = '0;
    b = '0;
    claimed_next = '0;
    for (int f = 0; f < NUM_FUNC; f++) begin
      map_next[f] = '0;
    end
    // UART bypasses the priority search
    if (want[F_TX]) begin
      map_next[F_TX] = '{valid: 1'b1, pin: UART_TX_PIN};
      map_next[F_RX] = '{valid: 1'b1, pin: UART_RX_PIN};
      taken[UART_TX_PIN] = 1'b1;
      taken[UART_RX_PIN] = 1'b1;
    end
    for (int f = F_SCK; f < NUM_FUNC; f++) begin
      if (want[f] && f != F_SCL) begin
        a = first_free(taken);
        if (f == F_SDA) begin
          b = first_free(taken | (NUM_PINS'(1) << a.pin));
          // Lone pin left over stays port I/O rather than half a bus
          if (a.valid && b.valid) begin
            map_next[F_SDA] = a;
            map_next[F_SCL] = b;
            taken[a.pin] = 1'b1;
            taken[b.pin] = 1'b1;
          end
        end else if (a.valid) begin
          map_next[f] = a;
          taken[a.pin] = 1'b1;
        end
      end
    end
    for (int f = 0; f < NUM_FUNC; f++) begin
      claimed_next = claimed_next + CNT_W'(map_next[f].valid);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int f = 0; f < NUM_FUNC; f++) begin
        map_reg[f] <= '0;
      end
      claimed_reg <= '0;
    end else begin
      for (int f = 0; f < NUM_FUNC; f++) begin
        map_reg[f] <= map_next[f];
      end
      claimed_reg <= claimed_next;
    end
  end

  // ==========================================================================
  // Pin ownership from the registered map
  always_comb begin
    own_valid = '0;
    smb_pin = '0;
    for (int p = 0; p < NUM_PINS; p++) begin
      own_func[p] = '0;
    end
    for (int f = 0; f < NUM_FUNC; f++) begin
      if (map_reg[f].valid) begin
        own_valid[map_reg[f].pin] = 1'b1;
        own_func[map_reg[f].pin] = PIN_IDX_W'(f);
        if (f == F_SDA || f == F_SCL) begin
          smb_pin[map_reg[f].pin] = 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Pin drivers; extra register stage keeps every output a flip-flop
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= '0;
      pin_oe_n <= '1;
      pin_pullup_en <= '0;
    end else begin
      for (int p = 0; p < NUM_PINS; p++) begin
        logic dig;
        logic od;
        logic val;
        logic req;
        logic drv;
        dig = in_mode_reg[p];
        od = !out_mode_reg[p] || smb_pin[p];
        val = port_latch[p];
        req = 1'b1;
        if (own_valid[p]) begin
          val = periph.value[own_func[p]];
          req = periph.drive[own_func[p]];
        end
        // Open-drain never drives high
        drv = xbar_en && dig && req && (!od || !val);
        pin_out[p] <= val;
        pin_oe_n[p] <= !drv;
        pin_pullup_en[p] <= dig && od && !pud && !(drv && !val);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_odhiz <= '0;
    end else begin
      pin_odhiz <= overdrive_reg;
    end
  end

  // ==========================================================================
  // Input side; analog pins read zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_level <= '0;
      periph_in <= '0;
    end else begin
      pin_level <= pin_sync & in_mode_reg;
      for (int f = 0; f < NUM_FUNC; f++) begin
        periph_in[f] <= map_reg[f].valid && pin_sync[map_reg[f].pin] &&
                        in_mode_reg[map_reg[f].pin];
      end
    end
  end

  // ==========================================================================
  // Checks
  chk_uart_fixed_pins: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (xbar_en && route_low_reg[B_UART]) |=>
      (map_reg[F_TX].valid && map_reg[F_TX].pin == UART_TX_PIN &&
       map_reg[F_RX].valid && map_reg[F_RX].pin == UART_RX_PIN))
    else $error("uart pins not fixed");

  chk_smb_pair_whole: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    map_reg[F_SDA].valid == map_reg[F_SCL].valid)
    else $error("smbus pin pair split");

  chk_nss_three_wire: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !spi_four_wire |=> !map_reg[F_NSS].valid)
    else $error("slave select routed in three-wire mode");

  chk_disabled_no_drive: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !xbar_en ##1 !xbar_en |=> (&pin_oe_n) && claimed_reg == '0)
    else $error("driver on while crossbar disabled");

  chk_analog_all_off: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ##1 (((~$past(in_mode_reg)) & (~pin_oe_n | pin_pullup_en |
          pin_level)) == '0))
    else $error("analog pin not isolated");

  chk_pullup_drive_low: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (pin_pullup_en & ~pin_oe_n & ~pin_out) == '0)
    else $error("pullup on while driving low");

  chk_skip_unowned: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !(xbar_en && route_low_reg[B_UART]) |=>
      ($past(skip_reg) & own_valid) == '0)
    else $error("skipped pin was claimed");

  chk_reset_digital: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) |-> in_mode_reg == RST_IN_MODE)
    else $error("pins not digital after reset");

  chk_smb_open_drain: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ##1 (($past(smb_pin) & ~pin_oe_n & pin_out) == '0))
    else $error("smbus pin driven high");
endmodule // pxb_crossbar

//--- src/pxb_pkg.sv
package pxb_pkg;

  // ==========================================================================
  // Geometry
  localparam int NUM_PINS = 24;
  localparam int PORT_W = 8;
  localparam int NUM_FUNC = 22;
  localparam int PIN_IDX_W = 5;
  localparam int CNT_W = 5;
  localparam logic [PIN_IDX_W-1:0] UART_TX_PIN = 5'h04;
  localparam logic [PIN_IDX_W-1:0] UART_RX_PIN = 5'h05;

  // ==========================================================================
  // Register addresses
  localparam logic [7:0] ADDR_ROUTE_LOW = 8'hE1;
  localparam logic [7:0] ADDR_ROUTE_HIGH = 8'hE2;
  localparam logic [7:0] ADDR_CLAIMED = 8'hE3;
  localparam logic [7:0] ADDR_IN_MODE0 = 8'hF1;
  localparam logic [7:0] ADDR_IN_MODE1 = 8'hF2;
  localparam logic [7:0] ADDR_IN_MODE2 = 8'hF3;
  localparam logic [7:0] ADDR_OUT_MODE0 = 8'hA4;
  localparam logic [7:0] ADDR_OUT_MODE1 = 8'hA5;
  localparam logic [7:0] ADDR_OUT_MODE2 = 8'hA6;
  localparam logic [7:0] ADDR_SKIP0 = 8'hD4;
  localparam logic [7:0] ADDR_SKIP1 = 8'hD5;
  localparam logic [7:0] ADDR_SKIP2 = 8'hD6;
  localparam logic [7:0] ADDR_OVERDRIVE = 8'hD7;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_ROUTE = 8'h00;
  localparam logic [NUM_PINS-1:0] RST_IN_MODE = 24'hFFFFFF;
  localparam logic [NUM_PINS-1:0] RST_OUT_MODE = 24'h000000;
  localparam logic [NUM_PINS-1:0] RST_SKIP = 24'h000000;
  localparam logic [7:0] RST_OVERDRIVE = 8'h00;

  // ==========================================================================
  // Low routing register bits
  localparam int B_UART = 0;
  localparam int B_SPI = 1;
  localparam int B_SMB = 2;
  localparam int B_SYSCLK = 3;
  localparam int B_CMP0 = 4;
  localparam int B_CMP0A = 5;
  localparam int B_CMP1 = 6;
  localparam int B_CMP1A = 7;

  // High routing register bits
  localparam int B_CEX_LSB = 0;
  localparam int CEX_W = 3;
  localparam int B_ECI = 3;
  localparam int B_T0 = 4;
  localparam int B_T1 = 5;
  localparam int B_XBAR_EN = 6;
  localparam int B_PUD = 7;
  localparam int CEX_MAX = 6;

  // ==========================================================================
  // Function indices, in priority order
  localparam int F_TX = 0;
  localparam int F_RX = 1;
  localparam int F_SCK = 2;
  localparam int F_MISO = 3;
  localparam int F_MOSI = 4;
  localparam int F_NSS = 5;
  localparam int F_SDA = 6;
  localparam int F_SCL = 7;
  localparam int F_CP0 = 8;
  localparam int F_CP0A = 9;
  localparam int F_CP1 = 10;
  localparam int F_CP1A = 11;
  localparam int F_SYSCLK = 12;
  localparam int F_CAPTURE_OUTPUT_ZERO = 13;
  localparam int F_ECI = 19;
  localparam int F_T0 = 20;
  localparam int F_T1 = 21;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic valid;
    logic [PIN_IDX_W-1:0] pin;
  } pxb_slot_t;

  typedef struct packed {
    logic [NUM_FUNC-1:0] value;
    logic [NUM_FUNC-1:0] drive;
  } pxb_periph_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } pxb_sfr_req_t;

endpackage

//--- src/pxb_sync2.sv
`timescale 1ns/1ns
module pxb_sync2 #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // ==========================================================================
  // Two stages; first stage feeds only the second
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // pxb_sync2

//--- tb/pxb_crossbar_tb.sv
`timescale 1ns/1ns
`define CMP(nm, ex, ac) begin comparisons++; if ((ac) !== (ex)) begin \
  n_mismatch++; $display("BAD %s expected %h seen %h", nm, ex, ac); end end
module pxb_crossbar_tb;
  import pxb_pkg::*;
  typedef struct {
    logic is_pin;
    logic [7:0] rd;
    logic [7:0] hiz;
    logic [NUM_PINS-1:0] oe_n, pout, pmask, pull, lvl0, lvl, lmask;
    logic [NUM_FUNC-1:0] fin, fmask;
  } pxb_exp_t;
  // ========================================================================
  // Signals
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  pxb_sfr_req_t req = '0;
  logic spi_four_wire = 1'b0;
  pxb_periph_t periph = '0;
  logic [NUM_PINS-1:0] port_latch = '0;
  logic [NUM_PINS-1:0] ext_en = '0;
  logic [NUM_PINS-1:0] ext_val = '0;
  logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe_n, pin_pullup_en, pin_level;
  logic [7:0] sfr_rdata, pin_odhiz;
  logic [NUM_FUNC-1:0] periph_in;
  logic look = 1'b0;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [15:0] seed = 16'hBCD1;
  logic [7:0] lo, hi, ovd;
  logic [NUM_PINS-1:0] inm, outm, skp;
  int own [NUM_PINS];
  int cnt;
  pxb_exp_t exp_q [$];
  pxb_exp_t mon_e;
  localparam logic [7:0] ADR [14] = '{ADDR_IN_MODE0, ADDR_IN_MODE1,
    ADDR_IN_MODE2, ADDR_OUT_MODE0, ADDR_OUT_MODE1, ADDR_OUT_MODE2,
    ADDR_SKIP0, ADDR_SKIP1, ADDR_SKIP2, ADDR_OVERDRIVE, ADDR_ROUTE_LOW,
    ADDR_ROUTE_HIGH, ADDR_CLAIMED, 8'h00};

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  pxb_crossbar i_dut (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sfr_req(req),
    .sfr_rdata(sfr_rdata),
    .spi_four_wire(spi_four_wire),
    .periph(periph),
    .periph_in(periph_in),
    .port_latch(port_latch),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .pin_pullup_en(pin_pullup_en),
    .pin_odhiz(pin_odhiz),
    .pin_level(pin_level)
  );

  pxb_pin_model i_pads (
    .sys_clk(sys_clk),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .pin_pullup_en(pin_pullup_en),
    .ext_en(ext_en),
    .ext_val(ext_val),
    .pin_in(pin_in)
  );
  // ========================================================================
  // Reference model of the routing
  function automatic logic [23:0] rnd();
    logic [23:0] r;
    for (int i = 0; i < 24; i++) begin
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      r[i] = seed[0];
    end
    return r;
  endfunction

  function automatic int free_pin(input logic [NUM_PINS-1:0] t, input int s);
    for (int p = s; p < NUM_PINS; p++) if (!t[p]) return p;
    return -1;
  endfunction

  function automatic void build_map(input logic fw);
    logic [NUM_PINS-1:0] tk;
    logic [NUM_FUNC-1:0] fe;
    int a;
    int b;
    tk = skp;
    cnt = 0;
    fe = '0;
    fe[F_TX+:2] = {2{lo[B_UART]}};
    fe[F_SCK+:3] = {3{lo[B_SPI]}};
    fe[F_NSS] = lo[B_SPI] & fw;
    fe[F_SDA] = lo[B_SMB];
    fe[F_CP0] = lo[B_CMP0];
    fe[F_CP0A] = lo[B_CMP0A];
    fe[F_CP1] = lo[B_CMP1];
    fe[F_CP1A] = lo[B_CMP1A];
    fe[F_SYSCLK] = lo[B_SYSCLK];
    for (int k = 0; k < CEX_MAX; k++) fe[F_CAPTURE_OUTPUT_ZERO + k] = k < hi[2:0];
    if (hi[2:0] == 3'h7) fe[F_CAPTURE_OUTPUT_ZERO+:CEX_MAX] = '0;
    fe[F_ECI] = hi[B_ECI];
    fe[F_T0] = hi[B_T0];
    fe[F_T1] = hi[B_T1];
    if (!hi[B_XBAR_EN]) fe = '0;
    for (int p = 0; p < NUM_PINS; p++) own[p] = -1;
    if (fe[F_TX]) begin
      own[UART_TX_PIN] = F_TX;
      own[UART_RX_PIN] = F_RX;
      tk[UART_TX_PIN] = 1'b1;
      tk[UART_RX_PIN] = 1'b1;
    end
    // Two-wire bus takes its pair or nothing
    for (int f = F_SCK; f < NUM_FUNC; f++) begin
      a = fe[f] ? free_pin(tk, 0) : -1;
      b = (f == F_SDA && a >= 0) ? free_pin(tk, a + 1) : a;
      if (a >= 0 && b >= 0) begin
        own[a] = f;
        own[b] = (f == F_SDA) ? F_SCL : f;
        tk[a] = 1'b1;
        tk[b] = 1'b1;
      end
    end
    for (int p = 0; p < NUM_PINS; p++) cnt += int'(own[p] >= 0);
  endfunction

  function automatic logic [7:0] shd(input int i);
    case (i)
      0, 1, 2: return inm[i * 8 +: 8];
      3, 4, 5: return outm[(i - 3) * 8 +: 8];
      6, 7, 8: return skp[(i - 6) * 8 +: 8];
      9: return ovd;
      10: return lo;
      11: return hi;
      12: return {3'h0, cnt[4:0]};
      default: return 8'h00;
    endcase
  endfunction
  // ========================================================================
  // Drivers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    pxb_exp_t e;
    e = '{default: '0};
    e.rd = x;
    @(posedge sys_clk);
    req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge sys_clk);
    req.rd <= 1'b0;
    exp_q.push_back(e);
    look <= 1'b1;
    @(posedge sys_clk);
    look <= 1'b0;
  endtask

  task automatic check_regs();
    for (int i = 0; i < 14; i++) rd(ADR[i], shd(i));
  endtask

  task automatic pins();
    pxb_exp_t e;
    logic v, rq, od, dg, dv;
    int f;
    e = '{default: '0};
    e.is_pin = 1'b1;
    e.hiz = ovd;
    for (int p = 0; p < NUM_PINS; p++) begin
      f = own[p];
      dg = inm[p];
      od = !outm[p] || f == F_SDA || f == F_SCL;
      v = (f >= 0) ? periph.value[f] : port_latch[p];
      rq = (f >= 0) ? periph.drive[f] : 1'b1;
      dv = hi[B_XBAR_EN] & dg & rq & (!od | !v);
      e.oe_n[p] = !dv;
      e.pmask[p] = dv;
      e.pout[p] = v & dv;
      e.pull[p] = dg & od & !hi[B_PUD] & !(dv & !v);
      e.lvl0[p] = !dg;
      // Floating pads wander, so only settled levels are compared
      e.lmask[p] = dv | ext_en[p] | e.pull[p] | !dg;
      e.lvl[p] = dg & (dv ? v : (ext_en[p] ? ext_val[p] : e.pull[p]));
    end
    e.fmask = '1;
    for (int p = 0; p < NUM_PINS; p++) begin
      if (own[p] >= 0) begin
        e.fmask[own[p]] = e.lmask[p];
        e.fin[own[p]] = e.lvl[p];
      end
    end
    @(posedge sys_clk);
    exp_q.push_back(e);
    look <= 1'b1;
    @(posedge sys_clk);
    look <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    lo = RST_ROUTE;
    hi = RST_ROUTE;
    inm = RST_IN_MODE;
    outm = RST_OUT_MODE;
    skp = RST_SKIP;
    ovd = RST_OVERDRIVE;
    build_map(1'b0);
    // Pullups must pass the pin synchroniser before levels settle
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic run_cfg(input logic [7:0] l, input logic [7:0] h,
      input logic [23:0] im, input logic [23:0] om, input logic [23:0] sk,
      input logic [7:0] od, input logic fw);
    logic [23:0] r;
    inm = im;
    outm = om;
    skp = sk | ~im;
    ovd = od;
    lo = l;
    hi = h;
    build_map(fw);
    r = rnd();
    @(posedge sys_clk);
    spi_four_wire <= fw;
    periph.value <= r[NUM_FUNC-1:0];
    port_latch <= r | ~im;
    ext_val <= ~r;
    r = rnd();
    // Mostly driving, some idle requests
    periph.drive <= r[NUM_FUNC-1:0] | r[23:2];
    ext_en <= r;
    for (int i = 0; i < 12; i++) wr(ADR[i], shd(i));
    @(posedge sys_clk);
    req.wr <= 1'b0;
    repeat (6) @(posedge sys_clk);
    pins();
    rd(ADDR_CLAIMED, {3'h0, cnt[4:0]});
  endtask
  // ========================================================================
  // Monitor
  always @(posedge sys_clk) begin
    if (look) begin
      mon_e = exp_q.pop_front();
      if (mon_e.is_pin) begin
        `CMP("pin_oe_n", mon_e.oe_n, pin_oe_n)
        `CMP("pin_out", mon_e.pout, pin_out & mon_e.pmask)
        `CMP("pin_pullup_en", mon_e.pull, pin_pullup_en)
        `CMP("pin_level", 24'h000000, pin_level & mon_e.lvl0)
        `CMP("pin_odhiz", mon_e.hiz, pin_odhiz)
        `CMP("pin_level", mon_e.lvl, pin_level & mon_e.lmask)
        `CMP("periph_in", mon_e.fin, periph_in & mon_e.fmask)
      end else begin
        `CMP("sfr_rdata", mon_e.rd, sfr_rdata)
      end
    end
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      $display("BAD timeout expected finish seen hang");
      close_out();
    end
  end

  task automatic close_out();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ========================================================================
  // Main sequence
  initial begin
    logic [23:0] ra, rb, rc;
    do_reset();
    pins();
    check_regs();
    run_cfg(8'h07, 8'h40, '1, '1, '0, 8'h00, 1'b1);
    run_cfg(8'h07, 8'h40, '1, '1, '0, 8'h5A, 1'b0);
    for (int b = 0; b < 8; b++)
      run_cfg(8'h01 << b, 8'h40, '1, '0, '0, 8'h00, 1'b1);
    for (int c = 0; c < 8; c++)
      run_cfg(8'hFF, {5'h0F, c[2:0]}, '1, '1, '0, 8'hFF, 1'b1);
    run_cfg(8'hFF, 8'h3F, '1, '1, '0, 8'h00, 1'b1);
    run_cfg(8'h04, 8'h40, '1, '0, 24'hFFFFF7, 8'h00, 1'b1);
    run_cfg(8'h04, 8'h40, '1, '1, 24'hFFFF77, 8'h00, 1'b1);
    run_cfg(8'h01, 8'h40, '1, '1, 24'h000030, 8'h00, 1'b1);
    wr(ADDR_CLAIMED, 8'h1F);
    wr(8'h00, 8'hA5);
    @(posedge sys_clk);
    req.wr <= 1'b0;
    check_regs();
    for (int i = 0; i < 40; i++) begin
      ra = rnd();
      rb = rnd();
      rc = rnd();
      run_cfg(ra[7:0], ra[15:8] | 8'h40, rb | rc, rc, ra & rb, rb[7:0],
        rc[0]);
    end
    do_reset();
    pins();
    check_regs();
    close_out();
  end
endmodule // pxb_crossbar_tb

//--- tb/pxb_pin_model.sv
`timescale 1ns/1ns
// ==========================================================================
// Pads and the world outside them
module pxb_pin_model
  import pxb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [NUM_PINS-1:0] pin_oe_n,
  input wire logic [NUM_PINS-1:0] pin_pullup_en,
  input wire logic [NUM_PINS-1:0] ext_en,
  input wire logic [NUM_PINS-1:0] ext_val,
  output logic [NUM_PINS-1:0] pin_in
);
  logic [NUM_PINS-1:0] float_reg = '0;

  // Undriven pad without pullup wanders; never let it read as a clean 0
  always @(posedge sys_clk) begin
    float_reg <= ~pin_in;
  end

  // Device driver wins over the outside source, then the pullup
  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      if (!pin_oe_n[p]) begin
        pin_in[p] = pin_out[p];
      end else if (ext_en[p]) begin
        pin_in[p] = ext_val[p];
      end else if (pin_pullup_en[p]) begin
        pin_in[p] = 1'b1;
      end else begin
        pin_in[p] = float_reg[p];
      end
    end
  end
endmodule // pxb_pin_model
